//--- twsbf_pkg.sv
// Shared constants and types for the two-wire slave bit front end and its master end
package twsbf_pkg;
	// Main clock
	localparam int MCLK_PERIOD_NS = 25;
	// Master wait after supply is stable (power_up_wait_time), least time rounds up
	localparam int PUP_WAIT_US = 100;
	localparam int PUP_WAIT_CYC = (PUP_WAIT_US * 1000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam logic [11:0] PUP_LAST = 12'(PUP_WAIT_CYC - 1);
	// Master clock period on the link, split into four quarters
	localparam int SCL_PERIOD_NS = 2500;
	localparam int SCL_QTR_CYC = SCL_PERIOD_NS / (4 * MCLK_PERIOD_NS);
	localparam logic [4:0] QTR_LAST = 5'(SCL_QTR_CYC - 1);
	// Bit positions inside one nine-clock byte
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [3:0] CNT_STEP = 4'h1;
	// Quarter phases of one master clock cell
	localparam logic [1:0] PH_SET = 2'h0;
	localparam logic [1:0] PH_RISE = 2'h1;
	localparam logic [1:0] PH_MID = 2'h2;
	localparam logic [1:0] PH_FALL = 2'h3;
	// Master command codes
	typedef enum logic [1:0] {
		CMD_START = 2'h0,
		CMD_WRITE = 2'h1,
		CMD_READ = 2'h2,
		CMD_STOP = 2'h3
	} twsbf_cmd_type;
	// Device link states
	typedef enum logic [1:0] {
		D_POR = 2'h0,
		D_STANDBY = 2'h1,
		D_ACTIVE = 2'h2,
		D_WR_WAIT = 2'h3
	} twsbf_dev_state_type;
	// Master states
	typedef enum logic [2:0] {
		H_WAIT = 3'h0,
		H_IDLE = 3'h1,
		H_START = 3'h2,
		H_HELD = 3'h3,
		H_BYTE = 3'h4,
		H_STOP = 3'h5
	} twsbf_host_state_type;
endpackage

//--- twsbf_if.sv
// Two-wire bus carrier with open-drain resolution of both lines
`timescale 1ns/1ps
`default_nettype none
interface twsbf_if;
	logic scl_o;
	logic scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	// Pull-up gives the high level; any enabled low driver wins
	assign scl = scl_oe ? scl_o : 1'b1;
	assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);
	modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
	modport host (input scl, input sda, output scl_o, output scl_oe, output host_sda_o, output host_sda_oe);
endinterface
`default_nettype wire

//--- twsbf_dev.sv
// Two-wire slave bit front end: condition detection, byte shifting, acknowledge
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Held in reset until supply good, then standby
// - Master waits power-up time before first command
// - Sample on rising clock, drive on falling
// - Bytes shift most significant bit first
// - Ninth clock carries acknowledge or no-acknowledge
// - Master sends no gaps within a byte
// - Data changes only while clock low
// - Data fall with clock high is Start
// - Master opens every command with Start
// - Ignore bus until a Start is seen
// - Data rise with clock high is Stop
// - Repeated Start restarts without passing idle
// - Bus idle only when both lines high
// - No limit on bytes per transfer
// - Data line only pulled low or released
// - Pure target, clock is input only
// - Release after eighth fall, acknowledge through ninth
// - Master no-acknowledge makes device release line
// - Stop enters standby after write cycle ends
module twsbf_dev (
	input wire logic I_MCLK,
	input wire logic I_ARST_N,
	input wire logic I_LCLK,
	input wire logic I_SUPPLY_OK,
	input wire logic I_ACK_EN,
	input wire logic I_TX_MODE,
	input wire logic I_WR_BUSY,
	input wire logic I_TX_LOAD,
	input wire logic [7:0] I_TX_DATA,
	output logic [7:0] O_RX_DATA,
	output logic O_RX_VALID,
	output logic O_START,
	output logic O_STOP,
	output logic O_ACTIVE,
	output logic O_TX_READY,
	twsbf_if.dev BUS
);
	typedef struct packed {
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic scl_f, sda_f, scl_p, sda_p;
		logic [1:0] sok_s, txm_s, ack_s, wrb_s;
		logic [2:0] ld_s;
		twsbf_pkg::twsbf_dev_state_type st;
		logic act;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] txb;
		logic tx, nack, oe;
		logic [7:0] rxh;
		logic rx_t, start_t, stop_t, lda_t;
	} twsbf_link_type;
	typedef struct packed {
		logic [2:0] rx_s, sta_s, sto_s;
		logic [1:0] lda_s, act_s;
		logic [7:0] rdata, txh;
		logic rx_v, start, stop, ld_t, tx_rdy, act;
	} twsbf_main_type;
	twsbf_link_type lk_q, lk_d;
	twsbf_main_type mc_q, mc_d;
	logic rise, fall, start, stop;
	// Edges and bus conditions from the filtered lines
	assign rise = lk_q.scl_f & ~lk_q.scl_p;
	assign fall = ~lk_q.scl_f & lk_q.scl_p;
	assign start = lk_q.scl_f & lk_q.scl_p & lk_q.sda_p & ~lk_q.sda_f;
	assign stop = lk_q.scl_f & lk_q.scl_p & ~lk_q.sda_p & lk_q.sda_f;
	// Link side: sampled by the link clock, clock line is only an input
	always_comb
	begin
		lk_d = lk_q;
		lk_d.scl_s = {lk_q.scl_s[1:0], BUS.scl};
		lk_d.sda_s = {lk_q.sda_s[1:0], BUS.sda};
		// Take a new level only after two equal synchronised samples
		if (lk_q.scl_s[1] == lk_q.scl_s[2])
			lk_d.scl_f = lk_q.scl_s[2];
		if (lk_q.sda_s[1] == lk_q.sda_s[2])
			lk_d.sda_f = lk_q.sda_s[2];
		lk_d.scl_p = lk_q.scl_f;
		lk_d.sda_p = lk_q.sda_f;
		lk_d.sok_s = {lk_q.sok_s[0], I_SUPPLY_OK};
		lk_d.txm_s = {lk_q.txm_s[0], I_TX_MODE};
		lk_d.ack_s = {lk_q.ack_s[0], I_ACK_EN};
		lk_d.wrb_s = {lk_q.wrb_s[0], I_WR_BUSY};
		lk_d.ld_s = {lk_q.ld_s[1:0], mc_q.ld_t};
		// Transmit byte handed over; held stable by the main side until acknowledged
		if (lk_q.ld_s[2] != lk_q.ld_s[1])
		begin
			lk_d.txb = mc_q.txh;
			lk_d.lda_t = ~lk_q.lda_t;
		end
		case (lk_q.st)
			twsbf_pkg::D_POR:
			begin
				lk_d.oe = 1'b0;
				if (lk_q.sok_s[1])
					lk_d.st = twsbf_pkg::D_STANDBY;
			end
			twsbf_pkg::D_STANDBY:
			begin
				lk_d.oe = 1'b0;
				// Only a Start wakes the device
				if (start)
				begin
					lk_d.st = twsbf_pkg::D_ACTIVE;
					lk_d.cnt = 4'(twsbf_pkg::BIT_FIRST - twsbf_pkg::CNT_STEP); // Clock fall of the Start wraps to bit one
					lk_d.tx = 1'b0;
					lk_d.nack = 1'b0;
					lk_d.start_t = ~lk_q.start_t;
				end
			end
			twsbf_pkg::D_ACTIVE:
			begin
				if (start)
				begin
					// Repeated Start: new operation, its own clock fall wraps the count to bit one
					lk_d.cnt = 4'(twsbf_pkg::BIT_FIRST - twsbf_pkg::CNT_STEP);
					lk_d.tx = 1'b0;
					lk_d.nack = 1'b0;
					lk_d.oe = 1'b0;
					lk_d.start_t = ~lk_q.start_t;
				end
				else if (stop)
				begin
					lk_d.cnt = twsbf_pkg::BIT_FIRST;
					lk_d.oe = 1'b0;
					lk_d.stop_t = ~lk_q.stop_t;
					// A pending write cycle delays standby
					lk_d.st = lk_q.wrb_s[1] ? twsbf_pkg::D_WR_WAIT : twsbf_pkg::D_STANDBY;
				end
				else if (rise)
				begin
					if (lk_q.cnt == twsbf_pkg::ACK_BIT)
					begin
						if (lk_q.tx)
							lk_d.nack = lk_q.sda_f;
					end
					else if (!lk_q.tx)
					begin
						lk_d.sh = {lk_q.sh[6:0], lk_q.sda_f};
						if (lk_q.cnt == twsbf_pkg::BIT_LAST)
						begin
							lk_d.rxh = {lk_q.sh[6:0], lk_q.sda_f};
							lk_d.rx_t = ~lk_q.rx_t;
						end
					end
				end
				else if (fall)
				begin
					if (lk_q.cnt == twsbf_pkg::ACK_BIT)
					begin
						// End of ninth clock: wrap with no byte limit
						lk_d.cnt = twsbf_pkg::BIT_FIRST;
						if (lk_q.nack)
						begin
							lk_d.oe = 1'b0;
							lk_d.tx = 1'b1;
						end
						else if (lk_q.txm_s[1])
						begin
							lk_d.tx = 1'b1;
							lk_d.oe = ~lk_q.txb[7];
							lk_d.sh = {lk_q.txb[6:0], 1'b0};
						end
						else
						begin
							lk_d.tx = 1'b0;
							lk_d.oe = 1'b0;
						end
					end
					else
					begin
						lk_d.cnt = 4'(lk_q.cnt + twsbf_pkg::CNT_STEP);
						if (lk_q.cnt == twsbf_pkg::BIT_LAST)
							lk_d.oe = lk_q.tx ? 1'b0 : lk_q.ack_s[1];
						else if (lk_q.tx && !lk_q.nack)
						begin
							lk_d.oe = ~lk_q.sh[7];
							lk_d.sh = {lk_q.sh[6:0], 1'b0};
						end
					end
				end
			end
			twsbf_pkg::D_WR_WAIT:
			begin
				lk_d.oe = 1'b0;
				if (!lk_q.wrb_s[1])
					lk_d.st = twsbf_pkg::D_STANDBY;
			end
			default:
			begin
				lk_d.st = twsbf_pkg::D_POR;
				lk_d.oe = 1'b0;
			end
		endcase
		// Supply loss drops the device back into reset
		if (!lk_q.sok_s[1])
		begin
			lk_d.st = twsbf_pkg::D_POR;
			lk_d.oe = 1'b0;
		end
		lk_d.act = (lk_d.st == twsbf_pkg::D_ACTIVE);
	end
	// Link side registers
	always_ff @(posedge I_LCLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
			lk_q <= '0;
		else
			lk_q <= lk_d;
	end
	// Main side: toggles become pulses, levels pass three flops
	always_comb
	begin
		mc_d = mc_q;
		mc_d.rx_s = {mc_q.rx_s[1:0], lk_q.rx_t};
		mc_d.sta_s = {mc_q.sta_s[1:0], lk_q.start_t};
		mc_d.sto_s = {mc_q.sto_s[1:0], lk_q.stop_t};
		mc_d.lda_s = {mc_q.lda_s[0], lk_q.lda_t};
		mc_d.act_s = {mc_q.act_s[0], lk_q.act};
		mc_d.act = mc_q.act_s[1];
		mc_d.rx_v = mc_q.rx_s[2] ^ mc_q.rx_s[1];
		mc_d.start = mc_q.sta_s[2] ^ mc_q.sta_s[1];
		mc_d.stop = mc_q.sto_s[2] ^ mc_q.sto_s[1];
		// Received byte is stable for nine bus clocks after its toggle
		if (mc_q.rx_s[2] != mc_q.rx_s[1])
			mc_d.rdata = lk_q.rxh;
		if (I_TX_LOAD && mc_q.tx_rdy)
		begin
			mc_d.txh = I_TX_DATA;
			mc_d.ld_t = ~mc_q.ld_t;
			mc_d.tx_rdy = 1'b0;
		end
		else
			mc_d.tx_rdy = (mc_q.lda_s[1] == mc_q.ld_t);
	end
	// Main side registers
	always_ff @(posedge I_MCLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
			mc_q <= '0;
		else
			mc_q <= mc_d;
	end
	assign O_RX_DATA = mc_q.rdata;
	assign O_RX_VALID = mc_q.rx_v;
	assign O_START = mc_q.start;
	assign O_STOP = mc_q.stop;
	assign O_ACTIVE = mc_q.act;
	assign O_TX_READY = mc_q.tx_rdy;
	// Open drain: output value fixed low, enable from a flop
	assign BUS.dev_sda_o = 1'b0;
	assign BUS.dev_sda_oe = lk_q.oe;
endmodule // twsbf_dev
`default_nettype wire

//--- twsbf_host.sv
// Two-wire bus master end: clock divider, Start, Stop and byte cells
`timescale 1ns/1ps
`default_nettype none
module twsbf_host (
	input wire logic I_MCLK,
	input wire logic I_ARST_N,
	input wire logic I_CMD_VALID,
	input wire logic [1:0] I_CMD,
	input wire logic [7:0] I_WDATA,
	input wire logic I_ACK,
	output logic O_READY,
	output logic O_DONE,
	output logic [7:0] O_RDATA,
	output logic O_ACK_RX,
	twsbf_if.host BUS
);
	typedef struct packed {
		twsbf_pkg::twsbf_host_state_type st;
		logic [11:0] pup;
		logic [4:0] tmr;
		logic [1:0] ph;
		logic [3:0] bitn;
		logic [7:0] sh;
		logic rd;
		logic ackq;
		logic scl_oe;
		logic sda_oe;
		logic ready;
		logic done;
		logic [7:0] rdata;
		logic ackr;
		logic [1:0] sda_s;
	} twsbf_hst_type;
	twsbf_hst_type h_q;
	twsbf_hst_type h_d;
	logic tick;
	// Quarter-period divider, clock cell steps and command intake
	always_comb
	begin
		h_d = h_q;
		h_d.done = 1'b0;
		h_d.sda_s = {h_q.sda_s[0], BUS.sda};
		tick = (h_q.tmr == twsbf_pkg::QTR_LAST);
		h_d.tmr = tick ? 5'h00 : 5'(h_q.tmr + 5'h01);
		if (tick && (h_q.st == twsbf_pkg::H_START || h_q.st == twsbf_pkg::H_BYTE || h_q.st == twsbf_pkg::H_STOP))
			h_d.ph = 2'(h_q.ph + 2'h1);
		case (h_q.st)
			twsbf_pkg::H_WAIT:
			begin
				// Hold off the first command after power-up
				if (h_q.pup == twsbf_pkg::PUP_LAST)
				begin
					h_d.st = twsbf_pkg::H_IDLE;
					h_d.ready = 1'b1;
				end
				else
					h_d.pup = 12'(h_q.pup + 12'h001);
			end
			twsbf_pkg::H_IDLE, twsbf_pkg::H_HELD:
			begin
				// Receiver lets go of the line a quarter after the ninth fall
				if (tick && h_q.st == twsbf_pkg::H_HELD)
					h_d.sda_oe = 1'b0;
				if (I_CMD_VALID && h_q.ready)
				begin
					h_d.ph = twsbf_pkg::PH_SET;
					h_d.ready = 1'b0;
					case (twsbf_pkg::twsbf_cmd_type'(I_CMD))
						twsbf_pkg::CMD_START:
							h_d.st = twsbf_pkg::H_START;
						twsbf_pkg::CMD_STOP:
						begin
							h_d.st = (h_q.st == twsbf_pkg::H_HELD) ? twsbf_pkg::H_STOP : h_q.st;
							h_d.ready = (h_q.st != twsbf_pkg::H_HELD);
						end
						default:
						begin
							// Bytes only after a Start
							h_d.st = (h_q.st == twsbf_pkg::H_HELD) ? twsbf_pkg::H_BYTE : h_q.st;
							h_d.ready = (h_q.st != twsbf_pkg::H_HELD);
							h_d.sh = I_WDATA;
							h_d.rd = (I_CMD == twsbf_pkg::CMD_READ);
							h_d.ackq = I_ACK;
							h_d.bitn = twsbf_pkg::BIT_FIRST;
						end
					endcase
				end
			end
			twsbf_pkg::H_START:
			begin
				if (tick)
				begin
					case (h_q.ph)
						twsbf_pkg::PH_SET: h_d.sda_oe = 1'b0;
						twsbf_pkg::PH_RISE: h_d.scl_oe = 1'b0;
						twsbf_pkg::PH_MID: h_d.sda_oe = 1'b1;
						default:
						begin
							h_d.scl_oe = 1'b1;
							h_d.st = twsbf_pkg::H_HELD;
							h_d.ready = 1'b1;
							h_d.done = 1'b1;
						end
					endcase
				end
			end
			twsbf_pkg::H_BYTE:
			begin
				if (tick)
				begin
					case (h_q.ph)
						twsbf_pkg::PH_SET:
						begin
							// Data set only while the clock is low, top bit first
							if (h_q.bitn == twsbf_pkg::ACK_BIT)
								h_d.sda_oe = h_q.rd & h_q.ackq;
							else
								h_d.sda_oe = ~h_q.rd & ~h_q.sh[7];
						end
						twsbf_pkg::PH_RISE: h_d.scl_oe = 1'b0;
						twsbf_pkg::PH_MID:
						begin
							if (h_q.bitn == twsbf_pkg::ACK_BIT)
								h_d.ackr = h_q.sda_s[1];
							else
								h_d.sh = {h_q.sh[6:0], h_q.sda_s[1]};
						end
						default:
						begin
							h_d.scl_oe = 1'b1;
							// Nine back-to-back cells with no gap
							if (h_q.bitn == twsbf_pkg::ACK_BIT)
							begin
								h_d.st = twsbf_pkg::H_HELD;
								h_d.ready = 1'b1;
								h_d.done = 1'b1;
								h_d.rdata = h_q.sh;
							end
							else
								h_d.bitn = 4'(h_q.bitn + twsbf_pkg::CNT_STEP);
						end
					endcase
				end
			end
			twsbf_pkg::H_STOP:
			begin
				if (tick)
				begin
					case (h_q.ph)
						twsbf_pkg::PH_SET: h_d.sda_oe = 1'b1;
						twsbf_pkg::PH_RISE: h_d.scl_oe = 1'b0;
						twsbf_pkg::PH_MID: h_d.sda_oe = 1'b0;
						default:
						begin
							// Both lines left high: bus idle
							h_d.st = twsbf_pkg::H_IDLE;
							h_d.ready = 1'b1;
							h_d.done = 1'b1;
						end
					endcase
				end
			end
			default:
				h_d.st = twsbf_pkg::H_WAIT;
		endcase
	end
	// State register
	always_ff @(posedge I_MCLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
			h_q <= '0;
		else
			h_q <= h_d;
	end
	assign O_READY = h_q.ready;
	assign O_DONE = h_q.done;
	assign O_RDATA = h_q.rdata;
	assign O_ACK_RX = h_q.ackr;
	assign BUS.scl_o = 1'b0;
	assign BUS.scl_oe = h_q.scl_oe;
	assign BUS.host_sda_o = 1'b0;
	assign BUS.host_sda_oe = h_q.sda_oe;
endmodule // twsbf_host
`default_nettype wire

//--- twsbf_chk.sv
// Concurrent checks on the two-wire link joining master and device ends
`timescale 1ns/1ps
`default_nettype none
module twsbf_chk (
	input wire logic I_MCLK,
	input wire logic I_LCLK,
	input wire logic I_ARST_N,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic pscl_q;
	logic psda_q;
	logic frame_q;
	logic [3:0] cnt_q;
	logic cond;
	// Data edge while the clock line stays high
	assign cond = scl & pscl_q & (sda ^ psda_q);
	// Frame flag and clock count inside a nine-clock byte
	always_ff @(posedge I_MCLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			pscl_q <= 1'b1;
			psda_q <= 1'b1;
			frame_q <= 1'b0;
			cnt_q <= 4'h1;
		end
		else
		begin
			pscl_q <= scl;
			psda_q <= sda;
			if (cond)
				frame_q <= psda_q; // Start sets, Stop clears
			if (cond && psda_q)
				cnt_q <= 4'h0;
			else if (scl && !pscl_q)
				cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
		end
	end
	a_dev_drain_only: assert property (@(posedge I_LCLK) disable iff (!I_ARST_N)
		dev_sda_oe |-> !dev_sda_o) else $error("device drives data high");
	a_dev_change_low: assert property (@(posedge I_LCLK) disable iff (!I_ARST_N)
		$rose(dev_sda_oe) |-> !scl && !$past(scl, 2)) else $error("device drive began off clock low");
	a_dev_hold_high: assert property (@(posedge I_LCLK) disable iff (!I_ARST_N)
		scl && $past(scl) |-> $stable(dev_sda_oe)) else $error("device data moved in clock high");
	a_ack_holds: assert property (@(posedge I_LCLK) disable iff (!I_ARST_N)
		$rose(dev_sda_oe) |-> dev_sda_oe [*8]) else $error("device low level too short");
	a_quiet_idle: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
		dev_sda_oe |-> frame_q) else $error("device drove outside a frame");
	a_cond_release: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
		cond |-> (!dev_sda_oe) [*4]) else $error("device drove across a bus condition");
	a_nine_clocks: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
		cond |-> cnt_q == 4'h1) else $error("bus condition off a byte boundary");
	a_host_drain: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
		scl_oe || host_sda_oe |-> !(scl_oe && scl_o) && !(host_sda_oe && host_sda_o)) else $error("master drives high");
endmodule // twsbf_chk
`default_nettype wire

//--- twsbf_tb.sv
// Self-checking bench joining master and device ends over the two-wire link
`timescale 1ns/1ps
`default_nettype none
module twsbf_tb;
	logic mclk = 1'b0;
	logic lclk = 1'b0;
	logic arst_n = 1'b0;
	logic supply, ack_en, tx_mode, tx_load, cmd_valid, ack, wr_busy;
	logic rx_valid, st, sp, active, tx_ready, ready, done, ack_rx;
	logic [7:0] tx_data, wdata, rx_data, rdata, last_rx;
	logic [1:0] cmd;
	logic [2:0] flags;
	int errors = 0;
	int checks = 0;
	int n_rx = 0;
	int n_st = 0;
	int n_sp = 0;
	// Main clock and unrelated link clock
	always #12.5 mclk = ~mclk;
	always #80 lclk = ~lclk;
	assign flags = {tx_ready, done, ready};
	twsbf_if bus ();
	twsbf_dev i_twsbf_dev (.I_MCLK(mclk), .I_ARST_N(arst_n), .I_LCLK(lclk), .I_SUPPLY_OK(supply), .I_ACK_EN(ack_en),
		.I_TX_MODE(tx_mode), .I_WR_BUSY(wr_busy), .I_TX_LOAD(tx_load), .I_TX_DATA(tx_data), .O_RX_DATA(rx_data),
		.O_RX_VALID(rx_valid), .O_START(st), .O_STOP(sp), .O_ACTIVE(active), .O_TX_READY(tx_ready), .BUS(bus));
	twsbf_host i_twsbf_host (.I_MCLK(mclk), .I_ARST_N(arst_n), .I_CMD_VALID(cmd_valid), .I_CMD(cmd), .I_WDATA(wdata),
		.I_ACK(ack), .O_READY(ready), .O_DONE(done), .O_RDATA(rdata), .O_ACK_RX(ack_rx), .BUS(bus));
	twsbf_chk i_twsbf_chk (.I_MCLK(mclk), .I_LCLK(lclk), .I_ARST_N(arst_n), .scl_o(bus.scl_o), .scl_oe(bus.scl_oe),
		.host_sda_o(bus.host_sda_o), .host_sda_oe(bus.host_sda_oe), .dev_sda_o(bus.dev_sda_o),
		.dev_sda_oe(bus.dev_sda_oe), .scl(bus.scl), .sda(bus.sda));
	// Count device user-side pulses where they are settled
	always @(negedge mclk)
	begin
		n_rx += int'(rx_valid === 1'b1);
		n_st += int'(st === 1'b1);
		n_sp += int'(sp === 1'b1);
		if (rx_valid === 1'b1)
			last_rx = rx_data;
	end
	task automatic finish_test();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Bounded wait at falling edges for ready, done or load-free flag
	task automatic wait_for(input int sel, input int lim);
		int n = 0;
		while (flags[sel] !== 1'b1)
		begin
			@(negedge mclk);
			n++;
			if (n > lim)
			begin
				chk(8'h00, 8'h01);
				finish_test();
			end
		end
	endtask
	// One master command, held until taken, then settle time for the device side
	task automatic run_cmd(input logic [1:0] c, input logic [7:0] d, input logic a);
		wait_for(0, 200);
		cmd_valid = 1'b1;
		cmd = c;
		wdata = d;
		ack = a;
		@(negedge mclk);
		cmd_valid = 1'b0;
		wait_for(1, 2000);
		repeat (60) @(negedge mclk);
	endtask
	task automatic do_start();
		run_cmd(twsbf_pkg::CMD_START, 8'h00, 1'b0);
	endtask
	task automatic do_stop();
		run_cmd(twsbf_pkg::CMD_STOP, 8'h00, 1'b0);
	endtask
	task automatic do_wr(input logic [7:0] d);
		run_cmd(twsbf_pkg::CMD_WRITE, d, 1'b0);
	endtask
	task automatic do_rd(input logic a);
		run_cmd(twsbf_pkg::CMD_READ, 8'h00, a);
	endtask
	task automatic load(input logic [7:0] d);
		wait_for(2, 400);
		tx_load = 1'b1;
		tx_data = d;
		@(negedge mclk);
		tx_load = 1'b0;
	endtask
	// Master waits out power-up; unpowered device stays silent
	task automatic t_power();
		repeat (3990) @(negedge mclk);
		chk({7'h0, ready}, 8'h00);
		wait_for(0, 30);
		do_start();
		do_wr(8'ha5);
		chk({7'h0, ack_rx}, 8'h01);
		chk({7'h0, active}, 8'h00);
		chk(8'(n_st + n_rx), 8'h00);
		do_stop();
		supply = 1'b1;
		repeat (40) @(negedge mclk);
		$display("power test done");
	endtask
	// Several received bytes, bit order and acknowledge, then Stop
	task automatic t_write();
		logic [7:0] pat [4] = '{8'h80, 8'h01, 8'ha5, 8'h5a};
		int s0 = n_st;
		int r0 = n_rx;
		int p0 = n_sp;
		do_start();
		chk(8'(n_st - s0), 8'h01);
		chk({7'h0, active}, 8'h01);
		foreach (pat[i])
		begin
			do_wr(pat[i]);
			chk(last_rx, pat[i]);
			chk({7'h0, ack_rx}, 8'h00);
		end
		chk(8'(n_rx - r0), 8'h04);
		do_stop();
		chk({7'h0, active}, 8'h00);
		chk(8'(n_sp - p0), 8'h01);
		chk({6'h0, bus.scl, bus.sda}, 8'h03);
		$display("write test done");
	endtask
	// No-acknowledge, then repeated Start without a Stop
	task automatic t_restart();
		int s0 = n_st;
		int p0 = n_sp;
		ack_en = 1'b0;
		do_start();
		do_wr(8'h3c);
		chk({7'h0, ack_rx}, 8'h01);
		ack_en = 1'b1;
		do_start();
		chk(8'(n_st - s0), 8'h02);
		chk(8'(n_sp - p0), 8'h00);
		chk({7'h0, active}, 8'h01);
		do_wr(8'hc3);
		chk({7'h0, ack_rx}, 8'h00);
		do_stop();
		$display("restart test done");
	endtask
	// Device sends two bytes; master no-acknowledge ends it
	task automatic t_read();
		tx_mode = 1'b1;
		load(8'hc6);
		do_start();
		do_wr(8'ha1);
		load(8'h39);
		do_rd(1'b1);
		chk(rdata, 8'hc6);
		do_rd(1'b0);
		chk(rdata, 8'h39);
		chk({7'h0, bus.dev_sda_oe}, 8'h00);
		tx_mode = 1'b0;
		do_stop();
		$display("read test done");
	endtask
	// Pending write cycle holds the device out of standby after Stop
	task automatic t_wrwait();
		int s0 = n_st;
		int p0 = n_sp;
		wr_busy = 1'b1;
		do_start();
		do_wr(8'h5c);
		do_stop();
		chk({7'h0, active}, 8'h00);
		do_start();
		chk(8'(n_st - s0), 8'h01);
		do_wr(8'h17);
		chk({7'h0, ack_rx}, 8'h01);
		do_stop();
		chk(8'(n_sp - p0), 8'h01);
		wr_busy = 1'b0;
		repeat (40) @(negedge mclk);
		do_start();
		chk(8'(n_st - s0), 8'h02);
		chk({7'h0, active}, 8'h01);
		do_wr(8'h71);
		chk({7'h0, ack_rx}, 8'h00);
		do_stop();
		$display("write wait test done");
	endtask
	// Reset, then the scenarios in order
	initial
	begin
		supply = 1'b0;
		wr_busy = 1'b0;
		ack_en = 1'b1;
		tx_mode = 1'b0;
		tx_load = 1'b0;
		tx_data = 8'h00;
		cmd_valid = 1'b0;
		cmd = 2'h0;
		wdata = 8'h00;
		ack = 1'b0;
		repeat (3) @(posedge lclk);
		@(negedge mclk);
		arst_n = 1'b1;
		t_power();
		t_write();
		t_restart();
		t_read();
		t_wrwait();
		finish_test();
	end
endmodule // twsbf_tb
`default_nettype wire
